// ===== dbg_cfg.svh
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

// Register offsets inside the 1 kB register space
`define OFS_CTL1 10'h020
`define OFS_STATUS 10'h021
`define OFS_TRC_CTL 10'h022
`define OFS_CTL2 10'h023
`define OFS_TB_HIGH 10'h024
`define OFS_TB_LOW 10'h025
`define OFS_COUNT 10'h026
`define OFS_SEQ_FLAGS 10'h027
`define OFS_CMP_CTL 10'h028
`define OFS_CMP_AH 10'h029
`define OFS_CMP_AM 10'h02A
`define OFS_CMP_AL 10'h02B
`define OFS_CMP_DH 10'h02C
`define OFS_CMP_DL 10'h02D
`define OFS_CMP_MH 10'h02E
`define OFS_CMP_ML 10'h02F

// Control one fields
`define C1_ARM 7
`define C1_IMMEDIATE_TRIGGER 6
`define C1_BDM 4
`define C1_BRK 3
`define C1_BANK 1:0

// Trace control and control two fields
`define TC_SOURCE 6
`define TC_MODE 3:2
`define TC_ALIGN 0
`define C2_PAIR 1:0

// Status, count and sequencer flag fields
`define SR_FULL 7
`define SR_STATE 2:0
`define CNT_FIELD 5:0
`define SEQ_ADV 2:0
`define SEQ_JUMP 3

// Comparator control fields
`define CC_SIZE_EN 7
`define CC_SIZE 6
`define CC_TAG 5
`define CC_BRK 4
`define CC_DIR 3
`define CC_DIR_EN 2
`define CC_NDB 1
`define CC_EN 0
`define CC_MASK_B 8'hFD
`define CC_MASK_C 8'h3D

// Encodings
`define BANK_NONE 2'h3
`define PAIR_INSIDE 2'h1
`define PAIR_OUTSIDE 2'h2
`define TRC_NORMAL 2'h0
`define TRC_LOOP 2'h1
`define TRC_DETAIL 2'h2
`define TRC_PURE_PC 2'h3
`define SSF_IDLE 3'h0
`define SSF_ONE 3'h1
`define SSF_TWO 3'h2
`define SSF_THREE 3'h3
`define SSF_FINAL 3'h4

// Reset values
`define RST_BYTE 8'h00
`define RST_ADDR 18'h0_0000
`define RST_WORD 16'h0000
`define RST_MASK 16'h0000

// Trace store size
`define TB_DEPTH 7'h40
`define TB_ONE 7'h01
`define TB_TWO 7'h02
`define TB_EMPTY 7'h00

`endif

// ===== dbg_pkg.sv
package dbg_pkg;
   typedef struct packed {
      logic valid;
      logic rd;
      logic byte_sz;
      logic free;
      logic opfetch;
      logic [17:0] addr;
      logic [15:0] data;
   } bus_cycle_t;

   typedef struct packed {
      logic change_of_flow;
      logic exec;
      logic [17:0] pc;
   } flow_t;

   typedef struct packed {
      logic bdm_enable;
      logic bdm_active;
      logic bdm_hw_access;
      logic secure;
   } sys_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [2:0] {st_idle, st_one, st_two, st_three, st_final} seq_state_t;
endpackage

// ===== addr_comparator.sv
`include "dbg_cfg.svh"
module addr_comparator import dbg_pkg::*; #(
   parameter bit HAS_DATA = 1'b0,
   parameter bit HAS_SIZE = 1'b0
) (
   input wire logic [7:0] ctl,
   input wire logic [17:0] cmp_addr,
   input wire logic [15:0] cmp_data,
   input wire logic [15:0] cmp_mask,
   input wire bus_cycle_t bus,
   output logic qual,
   output logic simple_hit
);
   logic dir_ok;
   logic size_ok;
   logic data_ok;

   assign dir_ok = !ctl[`CC_DIR_EN] || (bus.rd == ctl[`CC_DIR]);
   assign size_ok = !HAS_SIZE || !ctl[`CC_SIZE_EN] || (bus.byte_sz == ctl[`CC_SIZE]);
   // Mask bit set means that data bit takes part; NOT_DATA_BUS inverts the sense
   assign data_ok = !HAS_DATA || ((((bus.data ^ cmp_data) & cmp_mask) == `RST_WORD) ^ ctl[`CC_NDB]);
   assign qual = bus.valid && ctl[`CC_EN] && dir_ok && size_ok;
   assign simple_hit = qual && (bus.addr == cmp_addr) && data_ok;
endmodule // addr_comparator

// ===== trace_store.sv
`include "dbg_cfg.svh"
module trace_store (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic wr,
   input wire logic wr_two,
   input wire logic wrap,
   input wire logic [15:0] wd_a,
   input wire logic [15:0] wd_b,
   input wire logic pop,
   output logic [15:0] rd_word,
   output logic [6:0] count,
   output logic full
);
   logic [15:0] mem [64];
   logic [5:0] wp_r;
   logic [6:0] cnt_r;
   logic [6:0] add;
   logic room;
   logic do_wr;
   logic [7:0] sum;

   assign add = wr_two ? `TB_TWO : `TB_ONE;
   // Begin-aligned capture stops when full; end-aligned keeps the newest words
   assign room = wrap || ({1'b0, cnt_r} + {1'b0, add}) <= {1'b0, `TB_DEPTH};
   assign do_wr = wr && room;
   assign sum = {1'b0, cnt_r} + {1'b0, (do_wr ? add : `TB_EMPTY)} - {7'h00, (pop && cnt_r != `TB_EMPTY)};
   assign count = cnt_r;
   assign full = (cnt_r == `TB_DEPTH);
   // Oldest word first
   assign rd_word = mem[wp_r - cnt_r[5:0]];

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_r] <= wd_a;
         if (wr_two) begin
            mem[wp_r + 6'h01] <= wd_b;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || clear) begin
         wp_r <= 6'h00;
         cnt_r <= `TB_EMPTY;
      end else begin
         if (do_wr) begin
            wp_r <= wp_r + add[5:0];
         end
         cnt_r <= (sum > {1'b0, `TB_DEPTH}) ? `TB_DEPTH : sum[6:0];
      end
   end
endmodule // trace_store

// ===== dbg_monitor.sv
`include "dbg_cfg.svh"
module dbg_monitor import dbg_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire bus_cycle_t bus,
   input wire flow_t flow,
   input wire logic instr_boundary,
   input wire logic [2:0] tag_exec,
   input wire sys_mode_t mode,
   output logic [2:0] tag_mark,
   output logic brk_bdm_req,
   output logic brk_swi_req,
   output logic armed
);
   logic arm_r;
   logic bdm_sel_r;
   logic brk_en_r;
   logic [1:0] bank_r;
   logic trace_source_enable_r;
   logic [1:0] trace_mode_select_r;
   logic trace_alignment_r;
   logic [1:0] pair_r;
   logic [3:0] scr_r [3];
   logic [7:0] ctl_r [3];
   logic [17:0] addr_r [3];
   logic [15:0] data_r;
   logic [15:0] mask_r;
   logic [2:0] mflags_r;
   logic [2:0] force_pend_r;
   logic [2:0] tag_mark_r;
   logic [17:0] last_pc_r;
   logic last_valid_r;
   logic brk_bdm_r;
   logic brk_swi_r;
   logic [7:0] rdata_r;
   logic [7:0] rd_nxt;
   seq_state_t state_r;
   seq_state_t state_nxt;

   logic wr_c1;
   logic wr_cfg;
   logic arm_rise;
   logic immediate_trigger_req;
   logic mon_en;
   logic trace_en;
   logic trace_alignment_begin;
   logic [2:0] qual;
   logic [2:0] simple_hit;
   logic [2:0] raw;
   logic [2:0] hit_evt;
   logic [3:0] cur_scr;
   logic adv;
   logic jump;
   logic session_end;
   logic cap_en;
   logic tb_wr;
   logic tb_two;
   logic [15:0] tb_a;
   logic [15:0] tb_b;
   logic tb_pop;
   logic [15:0] tb_word;
   logic [6:0] tb_count;
   logic tb_full;
   logic [2:0] ssf;
   logic bank_ok;

   assign wr_c1 = reg_req.wr && reg_req.addr == `OFS_CTL1;
   assign wr_cfg = reg_req.wr && !arm_r;
   assign arm_rise = wr_c1 && reg_req.wdata[`C1_ARM] && !arm_r;
   // Trigger only makes sense in a live session or in the write that arms it
   assign immediate_trigger_req = wr_c1 && reg_req.wdata[`C1_IMMEDIATE_TRIGGER] && (arm_r || reg_req.wdata[`C1_ARM]);
   assign mon_en = !mode.bdm_active && !mode.bdm_hw_access;
   assign trace_en = trace_source_enable_r && !mode.secure;
   assign trace_alignment_begin = trace_alignment_r;
   assign bank_ok = bank_r != `BANK_NONE;

   addr_comparator #(.HAS_DATA(1'b1), .HAS_SIZE(1'b0)) u_cmp_a (
      .ctl(ctl_r[0]),
      .cmp_addr(addr_r[0]),
      .cmp_data(data_r),
      .cmp_mask(mask_r),
      .bus(bus),
      .qual(qual[0]),
      .simple_hit(simple_hit[0])
   );

   addr_comparator #(.HAS_DATA(1'b0), .HAS_SIZE(1'b1)) u_cmp_b (
      .ctl(ctl_r[1]),
      .cmp_addr(addr_r[1]),
      .cmp_data(data_r),
      .cmp_mask(mask_r),
      .bus(bus),
      .qual(qual[1]),
      .simple_hit(simple_hit[1])
   );

   addr_comparator #(.HAS_DATA(1'b0), .HAS_SIZE(1'b0)) u_cmp_c (
      .ctl(ctl_r[2]),
      .cmp_addr(addr_r[2]),
      .cmp_data(data_r),
      .cmp_mask(mask_r),
      .bus(bus),
      .qual(qual[2]),
      .simple_hit(simple_hit[2])
   );

   // In range modes A holds the lower bound and B the upper; the pair reports as A
   always_comb begin
      raw = simple_hit;
      if (pair_r == `PAIR_INSIDE) begin
         raw[0] = qual[0] && bus.addr > addr_r[0] && bus.addr < addr_r[1];
         raw[1] = 1'b0;
      end else if (pair_r == `PAIR_OUTSIDE) begin
         raw[0] = qual[0] && (bus.addr < addr_r[0] || bus.addr > addr_r[1]);
         raw[1] = 1'b0;
      end
      raw = raw & {3{arm_r && mon_en}};
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (ctl_r[i][`CC_TAG]) begin
            hit_evt[i] = arm_r && mon_en && tag_exec[i];
         end else begin
            hit_evt[i] = force_pend_r[i] && instr_boundary;
         end
      end
   end

   // A match seen in a boundary cycle waits for the following boundary
   always_ff @(posedge clk) begin
      if (sys_rst || arm_rise) begin
         force_pend_r <= 3'h0;
         tag_mark_r <= 3'h0;
         mflags_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            force_pend_r[i] <= (raw[i] && !ctl_r[i][`CC_TAG]) || (force_pend_r[i] && !instr_boundary);
            tag_mark_r[i] <= raw[i] && ctl_r[i][`CC_TAG] && bus.opfetch;
         end
         mflags_r <= mflags_r | hit_evt;
      end
   end

   always_comb begin
      unique case (state_r)
         st_one: cur_scr = scr_r[0];
         st_two: cur_scr = scr_r[1];
         st_three: cur_scr = scr_r[2];
         default: cur_scr = 4'h0;
      endcase
   end

   assign adv = |(hit_evt & cur_scr[`SEQ_ADV]);
   assign jump = adv && cur_scr[`SEQ_JUMP];
   // Begin alignment runs until full; end alignment or no tracing ends at once
   assign session_end = state_r == st_final && (!trace_en || !trace_alignment_begin || tb_full);

   always_comb begin
      state_nxt = state_r;
      if (wr_c1 && !reg_req.wdata[`C1_ARM] && !reg_req.wdata[`C1_IMMEDIATE_TRIGGER]) begin
         state_nxt = st_idle;
      end else if (arm_rise && !reg_req.wdata[`C1_IMMEDIATE_TRIGGER]) begin
         state_nxt = st_one;
      end else if (immediate_trigger_req && !(state_r == st_final && trace_alignment_begin && trace_en)) begin
         state_nxt = st_final;
      end else if (|(hit_evt & {ctl_r[2][`CC_BRK], ctl_r[1][`CC_BRK], ctl_r[0][`CC_BRK]}) && state_r != st_idle) begin
         state_nxt = st_final;
      end else begin
         unique case (state_r)
            st_idle: state_nxt = st_idle;
            st_one: state_nxt = jump ? st_final : (adv ? st_two : st_one);
            st_two: state_nxt = jump ? st_final : (adv ? st_three : st_two);
            st_three: state_nxt = adv ? st_final : st_three;
            st_final: state_nxt = session_end ? st_idle : st_final;
         endcase
      end
   end

   // Background mode entry has no path into the arm bit, so a session survives it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= st_idle;
         arm_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (wr_c1) begin
            arm_r <= reg_req.wdata[`C1_ARM];
         end else if (session_end) begin
            arm_r <= 1'b0;
         end
      end
   end

   // Breakpoint type falls back to software interrupt without background debug
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         brk_bdm_r <= 1'b0;
         brk_swi_r <= 1'b0;
      end else begin
         brk_bdm_r <= session_end && brk_en_r && !mode.bdm_active && bdm_sel_r && mode.bdm_enable;
         brk_swi_r <= session_end && brk_en_r && !mode.bdm_active && !(bdm_sel_r && mode.bdm_enable);
      end
   end

   // Trace capture; each entry is one 16-bit word (two in detail mode), so address bits 17:16 are dropped
   always_comb begin
      cap_en = arm_r && trace_en && mon_en
         && (trace_alignment_begin ? state_r == st_final : (state_r != st_idle && state_r != st_final));
      tb_wr = 1'b0;
      tb_two = 1'b0;
      tb_a = flow.pc[15:0];
      tb_b = bus.data;
      unique case (trace_mode_select_r)
         `TRC_NORMAL: tb_wr = flow.change_of_flow;
         `TRC_LOOP: tb_wr = flow.change_of_flow && !(last_valid_r && flow.pc == last_pc_r);
         `TRC_DETAIL: begin
            tb_wr = bus.valid && !bus.free && !bus.opfetch;
            tb_two = 1'b1;
            tb_a = bus.addr[15:0];
         end
         `TRC_PURE_PC: tb_wr = flow.exec;
      endcase
      tb_wr = tb_wr && cap_en;
   end

   always_ff @(posedge clk) begin
      if (sys_rst || arm_rise) begin
         last_pc_r <= `RST_ADDR;
         last_valid_r <= 1'b0;
      end else if (tb_wr && !tb_two) begin
         last_pc_r <= flow.pc;
         last_valid_r <= 1'b1;
      end
   end

   assign tb_pop = reg_req.rd && reg_req.addr == `OFS_TB_LOW && !arm_r;

   trace_store u_store (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(arm_rise),
      .wr(tb_wr),
      .wr_two(tb_two),
      .wrap(!trace_alignment_begin),
      .wd_a(tb_a),
      .wd_b(tb_b),
      .pop(tb_pop),
      .rd_word(tb_word),
      .count(tb_count),
      .full(tb_full)
   );

   // Configuration registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bdm_sel_r <= 1'b0;
         brk_en_r <= 1'b0;
         bank_r <= 2'h0;
         trace_source_enable_r <= 1'b0;
         trace_mode_select_r <= `TRC_NORMAL;
         trace_alignment_r <= 1'b0;
         pair_r <= 2'h0;
         data_r <= `RST_WORD;
         mask_r <= `RST_MASK;
         for (int i = 0; i < 3; i++) begin
            scr_r[i] <= 4'h0;
            ctl_r[i] <= `RST_BYTE;
            addr_r[i] <= `RST_ADDR;
         end
      end else begin
         if (wr_c1) begin
            bank_r <= reg_req.wdata[`C1_BANK];
         end
         if (wr_cfg) begin
            unique case (reg_req.addr)
               `OFS_CTL1: begin
                  bdm_sel_r <= reg_req.wdata[`C1_BDM];
                  brk_en_r <= reg_req.wdata[`C1_BRK];
               end
               `OFS_TRC_CTL: begin
                  trace_source_enable_r <= reg_req.wdata[`TC_SOURCE];
                  trace_mode_select_r <= reg_req.wdata[`TC_MODE];
                  trace_alignment_r <= reg_req.wdata[`TC_ALIGN];
               end
               `OFS_CTL2: pair_r <= reg_req.wdata[`C2_PAIR];
               `OFS_SEQ_FLAGS: if (bank_ok) scr_r[bank_r] <= reg_req.wdata[3:0];
               `OFS_CMP_CTL: begin
                  if (bank_r == 2'h0) ctl_r[0] <= reg_req.wdata;
                  if (bank_r == 2'h1) ctl_r[1] <= reg_req.wdata & `CC_MASK_B;
                  if (bank_r == 2'h2) ctl_r[2] <= reg_req.wdata & `CC_MASK_C;
               end
               `OFS_CMP_AH: if (bank_ok) addr_r[bank_r][17:16] <= reg_req.wdata[1:0];
               `OFS_CMP_AM: if (bank_ok) addr_r[bank_r][15:8] <= reg_req.wdata;
               `OFS_CMP_AL: if (bank_ok) addr_r[bank_r][7:0] <= reg_req.wdata;
               `OFS_CMP_DH: if (bank_r == 2'h0) data_r[15:8] <= reg_req.wdata;
               `OFS_CMP_DL: if (bank_r == 2'h0) data_r[7:0] <= reg_req.wdata;
               `OFS_CMP_MH: if (bank_r == 2'h0) mask_r[15:8] <= reg_req.wdata;
               `OFS_CMP_ML: if (bank_r == 2'h0) mask_r[7:0] <= reg_req.wdata;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      unique case (state_r)
         st_idle: ssf = `SSF_IDLE;
         st_one: ssf = `SSF_ONE;
         st_two: ssf = `SSF_TWO;
         st_three: ssf = `SSF_THREE;
         st_final: ssf = `SSF_FINAL;
         default: ssf = `SSF_IDLE;
      endcase
   end

   // Read mux; trigger bit and unmapped bytes read zero
   always_comb begin
      rd_nxt = `RST_BYTE;
      unique case (reg_req.addr)
         `OFS_CTL1: begin
            rd_nxt[`C1_ARM] = arm_r;
            rd_nxt[`C1_BDM] = bdm_sel_r;
            rd_nxt[`C1_BRK] = brk_en_r;
            rd_nxt[`C1_BANK] = bank_r;
         end
         `OFS_STATUS: begin
            rd_nxt[`SR_FULL] = tb_full;
            rd_nxt[`SR_STATE] = ssf;
         end
         `OFS_TRC_CTL: begin
            rd_nxt[`TC_SOURCE] = trace_source_enable_r;
            rd_nxt[`TC_MODE] = trace_mode_select_r;
            rd_nxt[`TC_ALIGN] = trace_alignment_r;
         end
         `OFS_CTL2: rd_nxt[`C2_PAIR] = pair_r;
         `OFS_TB_HIGH: rd_nxt = arm_r ? `RST_BYTE : tb_word[15:8];
         `OFS_TB_LOW: rd_nxt = arm_r ? `RST_BYTE : tb_word[7:0];
         `OFS_COUNT: begin
            rd_nxt[`SR_FULL] = tb_full;
            rd_nxt[`CNT_FIELD] = tb_count[5:0];
         end
         `OFS_SEQ_FLAGS: rd_nxt = bank_ok ? {4'h0, scr_r[bank_r]} : {5'h00, mflags_r};
         `OFS_CMP_CTL: rd_nxt = bank_ok ? ctl_r[bank_r] : `RST_BYTE;
         `OFS_CMP_AH: rd_nxt = bank_ok ? {6'h00, addr_r[bank_r][17:16]} : `RST_BYTE;
         `OFS_CMP_AM: rd_nxt = bank_ok ? addr_r[bank_r][15:8] : `RST_BYTE;
         `OFS_CMP_AL: rd_nxt = bank_ok ? addr_r[bank_r][7:0] : `RST_BYTE;
         `OFS_CMP_DH: rd_nxt = (bank_r == 2'h0) ? data_r[15:8] : `RST_BYTE;
         `OFS_CMP_DL: rd_nxt = (bank_r == 2'h0) ? data_r[7:0] : `RST_BYTE;
         `OFS_CMP_MH: rd_nxt = (bank_r == 2'h0) ? mask_r[15:8] : `RST_BYTE;
         `OFS_CMP_ML: rd_nxt = (bank_r == 2'h0) ? mask_r[7:0] : `RST_BYTE;
         default: rd_nxt = `RST_BYTE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= `RST_BYTE;
      end else if (reg_req.rd) begin
         rdata_r <= rd_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign tag_mark = tag_mark_r;
   assign brk_bdm_req = brk_bdm_r;
   assign brk_swi_req = brk_swi_r;
   assign armed = arm_r;
endmodule // dbg_monitor

// ===== dbg_monitor_asserts.sv
module dbg_monitor_asserts import dbg_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire bus_cycle_t bus,
   input wire flow_t flow,
   input wire logic instr_boundary,
   input wire logic [2:0] tag_exec,
   input wire sys_mode_t mode,
   input wire logic [2:0] tag_mark,
   input wire logic brk_bdm_req,
   input wire logic brk_swi_req,
   input wire logic armed
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic ctl_wr;
   assign ctl_wr = reg_req.wr && reg_req.addr == 10'h020;
   property p_reset;
      $past(sys_rst) |-> !armed && !brk_bdm_req && !brk_swi_req && tag_mark == 3'h0 && reg_rdata == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not clear after reset");
   property p_arm;
      ctl_wr && reg_req.wdata[7:6] == 2'h2 |=> armed;
   endproperty
   a_arm: assert property (p_arm) else $error("arm write ignored");
   property p_disarm;
      ctl_wr && reg_req.wdata[7:6] == 2'h0 |=> !armed;
   endproperty
   a_disarm: assert property (p_disarm) else $error("disarm write ignored");
   property p_armed_rise;
      $rose(armed) |-> $past(ctl_wr && reg_req.wdata[7]);
   endproperty
   a_armed_rise: assert property (p_armed_rise) else $error("armed without arm write");
   property p_brk_one;
      brk_bdm_req || brk_swi_req |=> !brk_bdm_req && !brk_swi_req;
   endproperty
   a_brk_one: assert property (p_brk_one) else $error("breakpoint longer than one cycle");
   property p_brk_excl;
      !(brk_bdm_req && brk_swi_req);
   endproperty
   a_brk_excl: assert property (p_brk_excl) else $error("both breakpoint kinds at once");
   property p_brk_disarm;
      brk_bdm_req || brk_swi_req |-> !armed;
   endproperty
   a_brk_disarm: assert property (p_brk_disarm) else $error("still armed at breakpoint");
   property p_swi_only;
      !mode.bdm_enable && !$past(mode.bdm_enable) |-> !brk_bdm_req;
   endproperty
   a_swi_only: assert property (p_swi_only) else $error("background break while disabled");
   property p_active;
      $past(mode.bdm_active) |-> !brk_bdm_req && !brk_swi_req && tag_mark == 3'h0;
   endproperty
   a_active: assert property (p_active) else $error("activity while background active");
   property p_hw;
      mode.bdm_hw_access |=> tag_mark == 3'h0;
   endproperty
   a_hw: assert property (p_hw) else $error("tag during host access");
   property p_rdata_hold;
      !reg_req.rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
endmodule // dbg_monitor_asserts

bind dbg_monitor dbg_monitor_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .bus(bus), .flow(flow), .instr_boundary(instr_boundary), .tag_exec(tag_exec),
   .mode(mode), .tag_mark(tag_mark), .brk_bdm_req(brk_bdm_req), .brk_swi_req(brk_swi_req), .armed(armed));

// ===== cpu_bus_model.sv
module cpu_bus_model import dbg_pkg::*; (
   input wire logic clk,
   input wire logic go,
   input wire logic [17:0] addr,
   output bus_cycle_t bus,
   output logic instr_boundary
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bus = '0;
      instr_boundary = 1'h0;
   end
   always @(posedge clk) begin
      bus.valid <= go;
      bus.rd <= 1'h1;
      // Live cycles are opcode fetches so that tagging can mark them
      bus.opfetch <= go;
      // Idle bus shows inverted values, so a stale address cannot pass for a live one
      bus.addr <= go ? addr : ~bus.addr;
      bus.data <= ~bus.data;
      instr_boundary <= bus.valid;
   end
endmodule // cpu_bus_model

// ===== tb.sv
module tb import dbg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [1:0] pm; logic [17:0] ad; logic hit;} row_t;
   logic clk = 1'h0, sys_rst = 1'h1, go = 1'h0;
   logic [17:0] go_addr = 18'h0_0000;
   reg_req_t req = '0;
   sys_mode_t mode = '0;
   flow_t flow = '0;
   logic [2:0] tag_exec = 3'h0;
   bus_cycle_t bus;
   logic boundary, bdm_req, swi_req, armed;
   logic [2:0] tag_mark;
   logic [7:0] rdata, got;
   int n_errors = 0, total_checks = 0;
   // Comparator A at 0x01000 with break, B at 0x02000 without
   logic [17:0] cfg [7] = '{{10'h020, 8'h00}, {10'h028, 8'h11}, {10'h02A, 8'h10}, {10'h020, 8'h01},
      {10'h028, 8'h01}, {10'h02A, 8'h20}, {10'h020, 8'h08}};
   row_t rows [10] = '{'{2'h0, 18'h0_1000, 1'h1}, '{2'h0, 18'h0_1001, 1'h0}, '{2'h0, 18'h0_2000, 1'h0},
      '{2'h1, 18'h0_1000, 1'h0}, '{2'h1, 18'h0_1001, 1'h1}, '{2'h1, 18'h0_1FFF, 1'h1},
      '{2'h1, 18'h0_2000, 1'h0}, '{2'h2, 18'h0_0FFF, 1'h1}, '{2'h2, 18'h0_1000, 1'h0},
      '{2'h2, 18'h0_2001, 1'h1}};
   logic [9:0] rst_regs [8] = '{10'h020, 10'h021, 10'h022, 10'h023, 10'h026, 10'h028, 10'h02A, 10'h030};
   always #50 clk = ~clk;
   dbg_monitor dut_u (.clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .bus(bus),
      .flow(flow), .instr_boundary(boundary), .tag_exec(tag_exec), .mode(mode), .tag_mark(tag_mark),
      .brk_bdm_req(bdm_req), .brk_swi_req(swi_req), .armed(armed));
   cpu_bus_model cpu_u (.clk(clk), .go(go), .addr(go_addr), .bus(bus), .instr_boundary(boundary));
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{1'h1, 1'h0, a, d};
      @(posedge clk);
      #1;
      req.wr = 1'h0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{1'h0, 1'h1, a, 8'h00};
      @(posedge clk);
      #1;
      req.rd = 1'h0;
      d = rdata;
   endtask
   // Outcome as {tag marks, bdm, swi} gathered over a fixed span
   task automatic wait_brk(output logic [7:0] br);
      br = 8'h00;
      repeat (8) begin
         @(posedge clk);
         #1;
         br = br | {3'h0, tag_mark, bdm_req, swi_req};
      end
   endtask
   task automatic bus_hit(input logic [17:0] a, output logic [7:0] br);
      @(posedge clk);
      #1;
      go = 1'h1;
      go_addr = a;
      @(posedge clk);
      #1;
      go = 1'h0;
      wait_brk(br);
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'h0;
      foreach (cfg[i]) wr(cfg[i][17:8], cfg[i][7:0]);
      foreach (rows[i]) begin
         wr(10'h023, {6'h00, rows[i].pm});
         wr(10'h020, 8'h88);
         bus_hit(rows[i].ad, got);
         check(got, {7'h00, rows[i].hit});
         wr(10'h020, 8'h08);
      end
      wr(10'h020, 8'h80);
      rd(10'h021, got);
      check(got, 8'h01);
      wr(10'h022, 8'h4D);
      wr(10'h020, 8'h00);
      rd(10'h022, got);
      check(got, 8'h00);
      wr(10'h020, 8'h02);
      wr(10'h028, 8'hFF);
      rd(10'h028, got);
      check(got, 8'h3D);
      wr(10'h020, 8'h01);
      rd(10'h028, got);
      check(got, 8'h01);
      wr(10'h028, 8'hFF);
      rd(10'h028, got);
      check(got, 8'hFD);
      wr(10'h020, 8'h03);
      rd(10'h027, got);
      check(got, 8'h00);
      for (int k = 0; k < 2; k++) begin
         mode.bdm_enable = (k == 0);
         wr(10'h020, 8'h18);
         wr(10'h020, 8'h98);
         wr(10'h020, 8'hD8);
         wait_brk(got);
         check(got, (k == 0) ? 8'h02 : 8'h01);
      end
      wr(10'h020, 8'h08);
      wr(10'h023, 8'h00);
      wr(10'h020, 8'h88);
      mode = '{1'h1, 1'h1, 1'h1, 1'h0};
      bus_hit(18'h0_1000, got);
      check(got, 8'h00);
      mode = '0;
      bus_hit(18'h0_1000, got);
      check(got, 8'h01);
      wr(10'h028, 8'h31);
      wr(10'h020, 8'h88);
      bus_hit(18'h0_1000, got);
      check(got, 8'h04);
      tag_exec = 3'h1;
      @(posedge clk);
      #1;
      tag_exec = 3'h0;
      wait_brk(got);
      check(got, 8'h01);
      wr(10'h022, 8'h4D);
      for (int s = 1; s >= 0; s--) begin
         mode.secure = s[0];
         wr(10'h020, 8'hC0);
         for (int k = 0; k < 64; k++) begin
            flow = '{1'h0, 1'h1, {10'h00A, k[7:0]}};
            @(posedge clk);
            #1;
         end
         flow = '0;
         rd(10'h026, got);
         check(got, (s == 1) ? 8'h00 : 8'h80);
         check({7'h00, armed}, 8'h00);
      end
      for (int k = 0; k < 2; k++) begin
         rd(10'h024, got);
         check(got, 8'h0A);
         rd(10'h025, got);
         check(got, k[7:0]);
      end
      wr(10'h022, 8'h40);
      wr(10'h020, 8'h80);
      for (int k = 0; k < 4; k++) begin
         flow = '{(k < 3), 1'h1, {10'h00B, k[7:0]}};
         @(posedge clk);
         #1;
      end
      flow = '0;
      wr(10'h020, 8'hC0);
      rd(10'h026, got);
      check(got, 8'h03);
      @(posedge clk);
      #1;
      sys_rst = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'h0;
      foreach (rst_regs[i]) begin
         rd(rst_regs[i], got);
         check(got, 8'h00);
      end
      give_verdict();
   end
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule // tb
